// [serial_port_pkg.sv]
// Constants, field layouts and types of the four-mode serial port.
// Assumes a 25 MHz core clock and a 32-bit Avalon-MM register bus.
`default_nettype none
package serial_port_pkg;
  localparam int ADDR_W = 10;
  localparam int BIT_CNT_W = 16;
  // Register indices; the byte address is four times the index
  localparam logic [7:0] CTRL_IDX = 8'h98;
  localparam logic [7:0] BUF_IDX = 8'h99;
  localparam logic [7:0] BAUD_IDX = 8'ha0;
  localparam logic [7:0] IRQ_STAT_IDX = 8'ha1;
  localparam logic [7:0] IRQ_MASK_IDX = 8'ha2;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] BUF_RST = 8'h00;
  localparam logic [3:0] BAUD_RST = 4'h0;
  localparam logic [2:0] IRQ_RST = 3'h0;
  // Baud configuration bits
  localparam int BAUD_DBL_BIT = 0;
  localparam int TX_T2_BIT = 1;
  localparam int RX_T2_BIT = 2;
  localparam int RCPM_BIT = 3;
  // Interrupt status and mask bits
  localparam int IRQ_W = 3;
  localparam int IRQ_RX_BIT = 0;
  localparam int IRQ_TX_BIT = 1;
  localparam int IRQ_WAKE_BIT = 2;
  // Mode codes
  localparam logic [1:0] MODE_SHIFT = 2'h0;
  localparam logic [1:0] MODE_UART8 = 2'h1;
  localparam logic [1:0] MODE_UART9_FIXED = 2'h2;
  localparam logic [1:0] MODE_UART9_TIMER = 2'h3;
  // Timing
  localparam int CORE_CLK_HZ = 25_000_000;
  localparam int SHIFT_DIV = 12;
  localparam logic [3:0] SHIFT_LAST = 4'(SHIFT_DIV - 1);
  localparam logic [3:0] SHIFT_HALF = 4'(SHIFT_DIV / 2);
  localparam logic [5:0] MODE2_SLOW_LAST = 6'(64 - 1);
  localparam logic [5:0] MODE2_FAST_LAST = 6'(32 - 1);
  localparam logic [BIT_CNT_W-1:0] BIT_LEN_RST = 16'h0010;
  localparam logic [3:0] SHIFT_BITS = 4'h8;
  localparam logic [3:0] FRAME8_BITS = 4'ha;
  localparam logic [3:0] FRAME9_BITS = 4'hb;

  typedef struct packed {
    logic mode_sel_hi;
    logic mode_sel_lo;
    logic multiproc_addr_filter;
    logic rx_enable;
    logic tx_ninth_bit;
    logic rx_ninth_bit;
    logic tx_done_flag;
    logic rx_done_flag;
  } serial_control_t;

  typedef enum logic [0:0] {RX_HUNT, RX_SHIFT} rx_state_t;
endpackage
`default_nettype wire

// [serial_port.sv]
// Four-mode serial port with 9-bit multiprocessor filter and Avalon-MM slave.
// Assumes timer overflow inputs are one-cycle pulses synchronous to core_clk_in.
//
// Summary of operation
// - Async receive path double-buffered; next frame shifts in before the buffer is read.
// - Buffer write loads transmitter and starts; buffer read returns separate receive register.
// - Mode field picks shift, 8-bit timer, 9-bit fixed or 9-bit timer mode.
// - Mode 2 bit rate is core clock over 64, or over 32 when doubled.
// - Mode 1 frame is start, eight data bits and stop: ten bits.
// - Timer 1 rate sets modes 1 and 3; halved unless doubler set.
// - Either timer-2 select uses timer 2 overflow, overriding the doubler.
// - Modes 2 and 3 send start 0, eight data, ninth bit, stop 1.
// - No parity check; received ninth bit is stored for software and gates the filter.
// - In modes 2 and 3 with filter set, ninth bit 0 frames raise no receive flag.
// - Transmit flag set at end of transmission; only software clears it.
// - Receive flag set at end of reception; only software clears it.
// - Reduced-clock mode with receive enable: any receive pin transition wakes chip.
// - Mode 0 outputs core clock over 12 shift clock, data on receive pin.
// - Mode 0 data changes on shift clock rise, sampled on its fall.
// - Mode 0 transmit starts on buffer write with flag clear; flag set when sent.
// - Mode 0 receive begins with enable set and flag clear; flag set after byte.
//
// Chosen here: the Avalon-MM register port.
`default_nettype none
module serial_port
  import serial_port_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  input wire logic [ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic timer1_ovf_in,
  input wire logic timer2_ovf_in,
  input wire logic serial_in_pin_in,
  output logic serial_in_pin_out,
  output logic serial_in_pin_oe_out,
  output logic serial_out_pin_out,
  output logic reduced_clock_power_mode_out,
  output logic wake_out,
  output logic irq_out
);

  function automatic logic hit(input logic [ADDR_W-1:0] addr, input logic [7:0] idx);
    hit = (addr == {idx, 2'b00});
  endfunction

  // Bus slave: one wait cycle, then a single-cycle answer
  logic wait_q;
  logic [31:0] rdata_q;
  logic wr_lo;
  logic [7:0] wdat;
  serial_control_t ctrl_q;
  logic [7:0] rxbuf_q;
  logic [3:0] baud_q;
  logic [IRQ_W-1:0] stat_q;
  logic [IRQ_W-1:0] mask_q;
  logic irq_q;

  assign wr_lo = avs_write_in && !wait_q && avs_byteenable_in[0];
  assign wdat = avs_writedata_in[7:0];

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      wait_q <= 1'b1;
    else if ((avs_read_in || avs_write_in) && wait_q)
      wait_q <= 1'b0;
    else
      wait_q <= 1'b1;
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      rdata_q <= 32'h0;
    else if (avs_read_in && wait_q)
    begin
      if (hit(avs_address_in, CTRL_IDX))
        rdata_q <= {24'h0, ctrl_q};
      else if (hit(avs_address_in, BUF_IDX))
        rdata_q <= {24'h0, rxbuf_q};
      else if (hit(avs_address_in, BAUD_IDX))
        rdata_q <= {28'h0, baud_q};
      else if (hit(avs_address_in, IRQ_STAT_IDX))
        rdata_q <= {29'h0, stat_q};
      else if (hit(avs_address_in, IRQ_MASK_IDX))
        rdata_q <= {29'h0, mask_q};
      else
        rdata_q <= 32'h0;
    end
  end

  assign avs_waitrequest_out = wait_q;
  assign avs_readdata_out = rdata_q;

  // Mode and baud selection
  logic [1:0] mode;
  logic dbl;
  logic t2_sel;
  logic timer_src;
  logic half_q;
  logic [5:0] div_q;
  logic bit_tick;
  logic [BIT_CNT_W-1:0] per_cnt_q;
  logic [BIT_CNT_W-1:0] bit_len_q;

  assign mode = {ctrl_q.mode_sel_hi, ctrl_q.mode_sel_lo};
  assign dbl = baud_q[BAUD_DBL_BIT];
  assign t2_sel = baud_q[TX_T2_BIT] || baud_q[RX_T2_BIT];
  assign timer_src = t2_sel ? timer2_ovf_in : timer1_ovf_in;

  always_comb
  begin
    if (mode == MODE_UART9_FIXED)
      bit_tick = (div_q == (dbl ? MODE2_FAST_LAST : MODE2_SLOW_LAST));
    else
      bit_tick = timer_src && (t2_sel || dbl || half_q);
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      div_q <= 6'h0;
    else if (mode != MODE_UART9_FIXED || bit_tick)
      div_q <= 6'h0;
    else
      div_q <= div_q + 6'h1;
  end

  // Timer 1 rate is halved by passing every second overflow
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      half_q <= 1'b0;
    else if (timer_src && !t2_sel && !dbl)
      half_q <= !half_q;
  end

  // Bit period in core cycles, used as the receiver's oversampling count
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      per_cnt_q <= '0;
      bit_len_q <= BIT_LEN_RST;
    end
    else if (bit_tick)
    begin
      per_cnt_q <= '0;
      bit_len_q <= per_cnt_q + 16'h1;
    end
    else if (per_cnt_q != '1)
      per_cnt_q <= per_cnt_q + 16'h1;
  end

  // Shift engine: async transmit, and both directions of mode 0
  logic busy_q;
  logic sync_rx_q;
  logic [10:0] sh_q;
  logic [3:0] left_q;
  logic [3:0] ph_q;
  logic out_q;
  logic dout_oe_q;
  logic tx_done_ev;
  logic sync_rx_done_q;
  logic start_tx;
  logic start_sync_rx;
  logic in_prev_q;

  always_comb
  begin
    start_tx = wr_lo && hit(avs_address_in, BUF_IDX) && !busy_q &&
               (mode != MODE_SHIFT || !ctrl_q.tx_done_flag);
    start_sync_rx = mode == MODE_SHIFT && ctrl_q.rx_enable && !ctrl_q.rx_done_flag &&
                    !busy_q && !start_tx && !sync_rx_done_q;
    tx_done_ev = 1'b0;
    if (busy_q && !sync_rx_q)
    begin
      if (mode == MODE_SHIFT)
        tx_done_ev = (ph_q == SHIFT_HALF) && (left_q == 4'h1);
      else
        tx_done_ev = bit_tick && (left_q == 4'h0);
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      busy_q <= 1'b0;
      sync_rx_q <= 1'b0;
      sh_q <= 11'h7ff;
      left_q <= 4'h0;
      ph_q <= 4'h0;
      out_q <= 1'b1;
      dout_oe_q <= 1'b0;
      sync_rx_done_q <= 1'b0;
    end
    else
    begin
      sync_rx_done_q <= 1'b0;
      if (start_tx)
      begin
        busy_q <= 1'b1;
        sync_rx_q <= 1'b0;
        ph_q <= 4'h0;
        out_q <= 1'b1;
        if (mode == MODE_SHIFT)
        begin
          sh_q <= {3'h7, wdat};
          left_q <= SHIFT_BITS;
          dout_oe_q <= !wdat[0];
        end
        else if (mode[1])
        begin
          sh_q <= {1'b1, ctrl_q.tx_ninth_bit, wdat, 1'b0};
          left_q <= FRAME9_BITS;
        end
        else
        begin
          sh_q <= {2'h3, wdat, 1'b0};
          left_q <= FRAME8_BITS;
        end
      end
      else if (start_sync_rx)
      begin
        busy_q <= 1'b1;
        sync_rx_q <= 1'b1;
        ph_q <= 4'h0;
        left_q <= SHIFT_BITS;
        dout_oe_q <= 1'b0;
      end
      else if (busy_q && mode == MODE_SHIFT)
      begin
        ph_q <= (ph_q == SHIFT_LAST) ? 4'h0 : ph_q + 4'h1;
        if (ph_q == 4'h0)
        begin
          out_q <= 1'b0;
          if (sync_rx_q)
            sh_q <= {3'h7, serial_in_pin_in, sh_q[7:1]};
        end
        else if (ph_q == SHIFT_HALF)
        begin
          out_q <= 1'b1;
          left_q <= left_q - 4'h1;
          if (!sync_rx_q)
          begin
            sh_q <= {1'b1, sh_q[10:1]};
            dout_oe_q <= !sh_q[1] && (left_q != 4'h1);
          end
          if (left_q == 4'h1)
          begin
            busy_q <= 1'b0;
            sync_rx_done_q <= sync_rx_q;
          end
        end
      end
      else if (busy_q && bit_tick)
      begin
        if (left_q == 4'h0)
          busy_q <= 1'b0;
        else
        begin
          out_q <= sh_q[0];
          sh_q <= {1'b1, sh_q[10:1]};
          left_q <= left_q - 4'h1;
        end
      end
      else if (busy_q && sync_rx_q)
      begin
        busy_q <= 1'b0;
        dout_oe_q <= 1'b0;
      end
      else if (!busy_q)
      begin
        out_q <= 1'b1;
        dout_oe_q <= 1'b0;
      end
    end
  end

  assign serial_out_pin_out = out_q;
  assign serial_in_pin_out = 1'b0;
  assign serial_in_pin_oe_out = dout_oe_q;

  // Asynchronous receiver
  rx_state_t rx_state_q;
  logic [BIT_CNT_W-1:0] rx_cnt_q;
  logic [3:0] rx_idx_q;
  logic [10:0] rx_sh_q;
  logic async_done_q;
  logic [3:0] rx_bits;

  assign rx_bits = mode[1] ? FRAME9_BITS : FRAME8_BITS;

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      in_prev_q <= 1'b1;
    else
      in_prev_q <= serial_in_pin_in;
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      rx_state_q <= RX_HUNT;
      rx_cnt_q <= '0;
      rx_idx_q <= 4'h0;
      rx_sh_q <= 11'h0;
      async_done_q <= 1'b0;
    end
    else
    begin
      async_done_q <= 1'b0;
      unique case (rx_state_q)
        RX_HUNT:
          if (mode != MODE_SHIFT && ctrl_q.rx_enable && in_prev_q && !serial_in_pin_in)
          begin
            rx_state_q <= RX_SHIFT;
            rx_cnt_q <= bit_len_q >> 1;
            rx_idx_q <= 4'h0;
          end
        RX_SHIFT:
          if (mode == MODE_SHIFT)
            rx_state_q <= RX_HUNT;
          else if (rx_cnt_q == '0)
          begin
            rx_cnt_q <= bit_len_q - 16'h1;
            if (rx_idx_q == 4'h0 && serial_in_pin_in)
              rx_state_q <= RX_HUNT;
            else
            begin
              rx_sh_q <= {serial_in_pin_in, rx_sh_q[10:1]};
              rx_idx_q <= rx_idx_q + 4'h1;
              if (rx_idx_q == rx_bits - 4'h1)
              begin
                rx_state_q <= RX_HUNT;
                async_done_q <= 1'b1;
              end
            end
          end
          else
            rx_cnt_q <= rx_cnt_q - 16'h1;
      endcase
    end
  end

  // Receive buffer load and multiprocessor filter
  logic rx_ev;
  logic rx_load;
  logic [7:0] rx_data;
  logic rx_ninth;

  always_comb
  begin
    rx_data = sh_q[7:0];
    rx_ninth = ctrl_q.rx_ninth_bit;
    if (async_done_q)
    begin
      rx_data = mode[1] ? rx_sh_q[8:1] : rx_sh_q[9:2];
      rx_ninth = mode[1] ? rx_sh_q[9] : rx_sh_q[10];
    end
    rx_ev = async_done_q || sync_rx_done_q;
    rx_load = rx_ev && !ctrl_q.rx_done_flag &&
              (sync_rx_done_q || !mode[1] || !ctrl_q.multiproc_addr_filter || rx_ninth);
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      rxbuf_q <= BUF_RST;
    else if (rx_load)
      rxbuf_q <= rx_data;
  end

  // Control register; hardware sets win over software writes
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      ctrl_q <= CTRL_RST;
    else
    begin
      if (wr_lo && hit(avs_address_in, CTRL_IDX))
        ctrl_q <= wdat;
      if (tx_done_ev)
        ctrl_q.tx_done_flag <= 1'b1;
      if (rx_load)
      begin
        ctrl_q.rx_done_flag <= 1'b1;
        ctrl_q.rx_ninth_bit <= rx_ninth;
      end
    end
  end

  // Power and baud configuration, with receive-pin wakeup
  logic wake_ev;
  logic wake_q;

  assign wake_ev = baud_q[RCPM_BIT] && ctrl_q.rx_enable && (in_prev_q != serial_in_pin_in);

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      baud_q <= BAUD_RST;
      wake_q <= 1'b0;
    end
    else
    begin
      wake_q <= wake_ev;
      if (wr_lo && hit(avs_address_in, BAUD_IDX))
        baud_q <= wdat[3:0];
      if (wake_ev)
        baud_q[RCPM_BIT] <= 1'b0;
    end
  end

  assign reduced_clock_power_mode_out = baud_q[RCPM_BIT];
  assign wake_out = wake_q;

  // Interrupt status (write one to clear), mask and level output
  logic [IRQ_W-1:0] irq_ev;
  logic [IRQ_W-1:0] stat_clr;

  always_comb
  begin
    irq_ev = '0;
    irq_ev[IRQ_RX_BIT] = rx_load;
    irq_ev[IRQ_TX_BIT] = tx_done_ev;
    irq_ev[IRQ_WAKE_BIT] = wake_ev;
    stat_clr = (wr_lo && hit(avs_address_in, IRQ_STAT_IDX)) ? wdat[IRQ_W-1:0] : '0;
  end

  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      stat_q <= IRQ_RST;
      mask_q <= IRQ_RST;
      irq_q <= 1'b0;
    end
    else
    begin
      stat_q <= (stat_q & ~stat_clr) | irq_ev;
      if (wr_lo && hit(avs_address_in, IRQ_MASK_IDX))
        mask_q <= wdat[IRQ_W-1:0];
      irq_q <= |(stat_q & mask_q);
    end
  end

  assign irq_out = irq_q;

  logic ctrl_wr;
  assign ctrl_wr = wr_lo && hit(avs_address_in, CTRL_IDX);

  AST_TX_FLAG_STICKY:
  assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    ctrl_q.tx_done_flag && !ctrl_wr |=> ctrl_q.tx_done_flag)
    else $error("transmit flag cleared without software write");

  AST_RX_FLAG_STICKY:
  assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    ctrl_q.rx_done_flag && !ctrl_wr |=> ctrl_q.rx_done_flag)
    else $error("receive flag cleared without software write");

  AST_MODE2_RATE:
  assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    bit_tick && mode == MODE_UART9_FIXED && !dbl |-> ##64 (bit_tick || mode != MODE_UART9_FIXED || dbl))
    else $error("mode 2 bit period is not 64 cycles");

  AST_SHIFT_CLOCK:
  assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    $fell(out_q) && mode == MODE_SHIFT |-> (!out_q)[*6] ##1 out_q)
    else $error("mode 0 shift clock low phase not 6 cycles");

  AST_TX_START:
  assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    start_tx |=> busy_q && !sync_rx_q && left_q != 4'h0)
    else $error("buffer write did not start transmission");

  AST_FILTER:
  assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    async_done_q && mode[1] && ctrl_q.multiproc_addr_filter && !rx_ninth && !ctrl_q.rx_done_flag
    |=> !ctrl_q.rx_done_flag || $past(ctrl_wr))
    else $error("filtered data frame raised receive flag");

  AST_WAKE:
  assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    baud_q[RCPM_BIT] && ctrl_q.rx_enable && $changed(serial_in_pin_in)
    |=> wake_q && !baud_q[RCPM_BIT])
    else $error("receive pin transition did not wake");

  AST_BUS_ANSWER:
  assert property (@(posedge core_clk_in) disable iff (!rst_b_in)
    avs_read_in || avs_write_in |-> ##[0:1] !wait_q)
    else $error("bus request not answered within one cycle");

endmodule
`default_nettype wire

// [serial_peer.sv]
// Remote serial device: sends and catches asynchronous frames, and acts as a mode 0 shift peripheral.
// Assumes the bench resolves the open-drain data wire and passes its level in.
`default_nettype none
module serial_peer
(
  input wire logic clk_in,
  input wire logic out_pin_in,
  input wire logic data_wire_in,
  output logic drive_out
);
  timeunit 1ns;
  timeprecision 1ns;
  initial drive_out = 1'b1;

  // Frame bits LSB first; the line returns high after the last bit
  task automatic send(input logic [10:0] f, input int n, input int len);
    for (int i = 0; i <= n; i++)
    begin
      @(posedge clk_in);
      drive_out <= (i < n) ? f[i] : 1'b1;
      repeat (len - 1) @(posedge clk_in);
    end
  endtask

  task automatic pulse(input int len);
    @(posedge clk_in);
    drive_out <= 1'b0;
    repeat (len) @(posedge clk_in);
    drive_out <= 1'b1;
  endtask

  // Shift peripheral: first bit ready before the clock starts, next bit on each rising shift clock
  task automatic shift_in(input logic [7:0] d);
    drive_out <= d[0];
    for (int i = 1; i < 8; i++)
    begin
      @(posedge out_pin_in);
      drive_out <= d[i];
    end
    @(posedge out_pin_in);
    drive_out <= 1'b1;
  endtask

  // Waits for the start bit, then samples each bit in its middle
  task automatic catch_frame(input int n, input int len, output logic [10:0] f);
    int t;
    f = '0;
    t = 0;
    while (out_pin_in !== 1'b0 && t < 4000)
    begin
      @(posedge clk_in);
      t++;
    end
    repeat (len / 2) @(posedge clk_in);
    for (int i = 0; i < n; i++)
    begin
      f[i] = out_pin_in;
      repeat (len) @(posedge clk_in);
    end
  endtask

  // Samples the data wire at each falling shift clock edge
  task automatic catch_shift(output logic [7:0] d, output int span);
    longint t0;
    t0 = 0;
    for (int i = 0; i < 8; i++)
    begin
      @(negedge out_pin_in);
      d[i] = data_wire_in;
      if (i == 0)
        t0 = $time;
    end
    span = int'(($time - t0) / 40);
  endtask
endmodule
`default_nettype wire

// [tb.sv]
// Self-checking bench for the serial port: register tasks over Avalon-MM, a remote serial peer.
// Assumes a 25 MHz clock and timer overflow pulses made here.
`default_nettype none
module tb
  import serial_port_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [ADDR_W-1:0] addr = '0;
  logic rd_en = 1'b0;
  logic wr_en = 1'b0;
  logic [31:0] wdata = '0;
  logic [31:0] rdata;
  logic wait_req;
  logic t1_ovf = 1'b0;
  logic t2_ovf = 1'b0;
  logic pin_drv, pin_wire, pin_o, pin_oe, out_pin, rcpm, wake, irq;
  logic out_prev = 1'b1;
  int c1 = 0;
  int c2 = 0;
  int wake_count = 0;
  int fall_count = 0;
  int fail_count = 0;
  int compares = 0;
  logic [7:0] idx_tab [6] = '{CTRL_IDX, BUF_IDX, BAUD_IDX, IRQ_STAT_IDX, IRQ_MASK_IDX, 8'h90};
  logic [7:0] ctl_tab [6] = '{8'h88, 8'h80, 8'h40, 8'h40, 8'hc8, 8'hc0};
  logic [7:0] baud_tab [6] = '{8'h00, 8'h01, 8'h00, 8'h01, 8'h03, 8'h04};
  int len_tab [6] = '{64, 32, 16, 8, 6, 6};

  assign pin_wire = (pin_oe === 1'b1) ? pin_o : pin_drv;

  initial
    forever #20 clk = ~clk;

  // Timer 1 overflows every 8 cycles, timer 2 every 6
  always @(posedge clk)
  begin
    c1 <= (c1 == 7) ? 0 : c1 + 1;
    c2 <= (c2 == 5) ? 0 : c2 + 1;
    t1_ovf <= (c1 == 7);
    t2_ovf <= (c2 == 5);
    out_prev <= out_pin;
    if (wake === 1'b1)
      wake_count <= wake_count + 1;
    if (out_prev === 1'b1 && out_pin === 1'b0)
      fall_count <= fall_count + 1;
  end

  serial_port uut
  (
    .core_clk_in(clk),
    .rst_b_in(rst_b),
    .avs_address_in(addr),
    .avs_read_in(rd_en),
    .avs_write_in(wr_en),
    .avs_writedata_in(wdata),
    .avs_byteenable_in(4'h1),
    .avs_readdata_out(rdata),
    .avs_waitrequest_out(wait_req),
    .timer1_ovf_in(t1_ovf),
    .timer2_ovf_in(t2_ovf),
    .serial_in_pin_in(pin_wire),
    .serial_in_pin_out(pin_o),
    .serial_in_pin_oe_out(pin_oe),
    .serial_out_pin_out(out_pin),
    .reduced_clock_power_mode_out(rcpm),
    .wake_out(wake),
    .irq_out(irq)
  );

  serial_peer peer
  (
    .clk_in(clk),
    .out_pin_in(out_pin),
    .data_wire_in(pin_wire),
    .drive_out(pin_drv)
  );

  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    compares++;
    if (seen !== want)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, want, seen);
    end
  endtask

  // Holds the request until waitrequest is sampled low at a rising edge; data taken and request released there
  task automatic access(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    addr <= {idx, 2'b00};
    wr_en <= wr;
    rd_en <= !wr;
    wdata <= {24'h0, wd};
    @(posedge clk);
    while (wait_req !== 1'b0 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 20)
      fail_count++;
    rd = rdata[7:0];
    wr_en <= 1'b0;
    rd_en <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] x;
    access(1'b1, idx, d, x);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] idx, input logic [7:0] want);
    logic [7:0] v;
    access(1'b0, idx, 8'h00, v);
    check(what, {24'h0, v}, {24'h0, want});
  endtask

  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    tally_and_finish();
  end

  initial
  begin
    logic [7:0] v, d;
    logic [10:0] f, want;
    int span, n0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    check("idle line", {31'h0, out_pin}, 32'h1);
    wr(8'h90, 8'hff);
    foreach (idx_tab[i]) rd_chk("reset value", idx_tab[i], 8'h00);
    $display("test reset finished");
    for (int i = 0; i < 6; i++)
    begin
      d = 8'h35 + 8'(i * 17);
      want = ctl_tab[i][7] ? {1'b1, ctl_tab[i][3], d, 1'b0} : {2'b01, d, 1'b0};
      wr(BAUD_IDX, baud_tab[i]);
      wr(CTRL_IDX, ctl_tab[i]);
      fork
        peer.catch_frame(ctl_tab[i][7] ? 11 : 10, len_tab[i], f);
        wr(BUF_IDX, d);
      join
      check("async frame", {21'h0, f}, {21'h0, want});
      rd_chk("tx done", CTRL_IDX, ctl_tab[i] | 8'h02);
    end
    $display("test async transmit finished");
    wr(CTRL_IDX, 8'h00);
    fork
      peer.catch_shift(v, span);
      wr(BUF_IDX, 8'h96);
    join
    check("shift data", {24'h0, v}, 32'h96);
    check("shift clock span", 32'(span), 32'd84);
    repeat (12) @(posedge clk);
    rd_chk("shift done", CTRL_IDX, 8'h02);
    n0 = fall_count;
    wr(BUF_IDX, 8'h11);
    repeat (40) @(posedge clk);
    check("shift refused", 32'(fall_count - n0), 32'h0);
    fork
      peer.shift_in(8'ha5);
      wr(CTRL_IDX, 8'h10);
    join
    repeat (4) @(posedge clk);
    rd_chk("shift rx flags", CTRL_IDX, 8'h11);
    rd_chk("shift rx byte", BUF_IDX, 8'ha5);
    $display("test shift finished");
    wr(BAUD_IDX, 8'h08);
    wr(CTRL_IDX, 8'h40);
    n0 = wake_count;
    peer.pulse(2);
    repeat (4) @(posedge clk);
    check("no wake", {31'(wake_count - n0), rcpm}, 32'h1);
    wr(CTRL_IDX, 8'h50);
    peer.pulse(2);
    repeat (4) @(posedge clk);
    check("wake", {31'(wake_count - n0), rcpm}, 32'h2);
    $display("test wake finished");
    wr(BAUD_IDX, 8'h00);
    wr(CTRL_IDX, 8'hb0);
    // Receiver measures the bit period from two bit ticks of the new mode
    repeat (140) @(posedge clk);
    peer.send({2'b10, 8'h6c, 1'b0}, 11, 64);
    repeat (70) @(posedge clk);
    rd_chk("filtered frame", CTRL_IDX, 8'hb0);
    peer.send({2'b11, 8'hc9, 1'b0}, 11, 64);
    repeat (4) @(posedge clk);
    rd_chk("address frame", CTRL_IDX, 8'hb5);
    fork
      peer.send({2'b10, 8'h4e, 1'b0}, 11, 64);
      begin
        repeat (100) @(posedge clk);
        rd_chk("first byte", BUF_IDX, 8'hc9);
        wr(CTRL_IDX, 8'h90);
      end
    join
    repeat (4) @(posedge clk);
    rd_chk("second flags", CTRL_IDX, 8'h91);
    rd_chk("second byte", BUF_IDX, 8'h4e);
    $display("test receive finished");
    rd_chk("irq status", IRQ_STAT_IDX, 8'h07);
    wr(IRQ_MASK_IDX, 8'h01);
    repeat (2) @(posedge clk);
    check("irq raised", {31'h0, irq}, 32'h1);
    wr(IRQ_MASK_IDX, 8'h00);
    repeat (2) @(posedge clk);
    check("irq masked", {31'h0, irq}, 32'h0);
    wr(IRQ_MASK_IDX, 8'h01);
    wr(IRQ_STAT_IDX, 8'h01);
    repeat (2) @(posedge clk);
    check("irq cleared", {31'h0, irq}, 32'h0);
    rd_chk("irq status left", IRQ_STAT_IDX, 8'h06);
    $display("test interrupt finished");
    tally_and_finish();
  end
endmodule
`default_nettype wire
